// ===== rtl/isx_defs.svh
// Constants for the increment-and-skip execution block.
`ifndef ISX_DEFS_SVH
`define ISX_DEFS_SVH
`define ISX_OPC_SKIP_ZERO    6'h0f
`define ISX_OPC_SKIP_NONZERO 6'h12
`define ISX_OPC_MSB          15
`define ISX_OPC_LSB          10
`define ISX_DEST_BIT         9
`define ISX_ACCESS_BIT       8
`define ISX_LITERAL_OFS_MAX  8'h5f
`define ISX_ACCESS_SPLIT     8'h60
`define ISX_ACCESS_HI_BANK   4'hf
`define ISX_DATA_RESET       8'h00
`endif

// ===== rtl/isx_pkg.sv
// Types shared by the increment-and-skip execution block.
package isx_pkg;
    typedef enum logic [1:0]
    {
        ISX_PH_Q1 = 2'b00,
        ISX_PH_Q2 = 2'b01,
        ISX_PH_Q3 = 2'b10,
        ISX_PH_Q4 = 2'b11
    } isx_phase_t;

    typedef enum logic [1:0]
    {
        ISX_EX_IDLE  = 2'b00,
        ISX_EX_RUN   = 2'b01,
        ISX_EX_FLUSH = 2'b10,
        ISX_EX_FLUSH2 = 2'b11
    } isx_exec_t;

    // Decoded operand fields of one instruction word.
    typedef struct packed
    {
        logic       is_skip_zero;
        logic       is_skip_nonzero;
        logic       dest_file;
        logic       use_bank;
        logic [7:0] file_addr;
    } isx_decode_t;

    // File register access request: 12-bit address, data and write strobe.
    typedef struct packed
    {
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  data;
    } isx_file_wr_t;
endpackage : isx_pkg

// ===== rtl/isx_addr_gen.sv
// Effective file address generation for the increment-and-skip block.
`timescale 1ns/1ns
`include "isx_defs.svh"
module isx_addr_gen
    import isx_pkg::*;
(
    input  wire logic [7:0]  i_file_addr,
    input  wire logic        i_use_bank,
    input  wire logic [3:0]  i_bank_select_register,
    input  wire logic        i_ext_set_en,
    input  wire logic [11:0] i_index_base,
    output logic      [11:0] o_eff_addr
);
    wire logic        lit_mode;
    wire logic [11:0] lit_addr;
    wire logic [11:0] access_addr;
    wire logic [11:0] bank_addr;

    assign lit_mode    = !i_use_bank && i_ext_set_en && (i_file_addr <= `ISX_LITERAL_OFS_MAX);
    assign lit_addr    = i_index_base + {4'h0, i_file_addr};
    // The access bank maps low addresses to bank 0 and high ones to the top bank.
    assign access_addr = (i_file_addr < `ISX_ACCESS_SPLIT) ? {4'h0, i_file_addr}
                                                           : {`ISX_ACCESS_HI_BANK, i_file_addr};
    assign bank_addr   = {i_bank_select_register, i_file_addr};
    assign o_eff_addr  = lit_mode ? lit_addr : (i_use_bank ? bank_addr : access_addr);
endmodule : isx_addr_gen

// ===== rtl/isx_exec.sv
// Execution unit for the increment-and-skip-if-zero and increment-and-skip-if-nonzero instructions.
`timescale 1ns/1ns
`include "isx_defs.svh"
module isx_exec
    import isx_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_instr_valid,
    input  wire logic [15:0] i_instr,
    input  wire logic        i_next_two_word,
    input  wire logic [3:0]  i_bank_select_register,
    input  wire logic        i_ext_set_en,
    input  wire logic [11:0] i_index_base,
    input  wire logic [7:0]  i_file_rdata,
    output logic      [11:0] o_file_addr,
    output logic             o_file_wr,
    output logic      [7:0]  o_file_wdata,
    output logic             o_acc_wr,
    output logic      [7:0]  o_acc_wdata,
    output logic             o_flush,
    output logic             o_busy,
    output logic      [1:0]  o_phase
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic isx_decode_t isx_decode(input logic [15:0] word);
        isx_decode_t r;
        r.is_skip_zero    = (word[`ISX_OPC_MSB:`ISX_OPC_LSB] == `ISX_OPC_SKIP_ZERO);
        r.is_skip_nonzero = (word[`ISX_OPC_MSB:`ISX_OPC_LSB] == `ISX_OPC_SKIP_NONZERO);
        r.dest_file       = word[`ISX_DEST_BIT];
        r.use_bank        = word[`ISX_ACCESS_BIT];
        r.file_addr       = word[7:0];
        return r;
    endfunction : isx_decode

    isx_decode_t dec_in;
    isx_decode_t dec_q;
    isx_decode_t dec_d;
    wire logic   accept;
    wire logic [11:0] eff_addr;

    assign dec_in = isx_decode(i_instr);

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    isx_phase_t  phase_q;
    isx_phase_t  phase_d;
    isx_exec_t   state_q;
    isx_exec_t   state_d;
    logic [7:0]  operand_q;
    logic        two_word_q;
    wire  logic [7:0] sum;
    wire  logic  result_zero;
    wire  logic  skip;
    wire  logic  last_phase;

    assign last_phase  = (phase_q == ISX_PH_Q4);
    assign sum         = operand_q + 8'h01;
    assign result_zero = (sum == `ISX_DATA_RESET);
    assign skip        = (dec_q.is_skip_zero && result_zero)
                      || (dec_q.is_skip_nonzero && !result_zero);
    assign accept      = (state_q == ISX_EX_IDLE) && (phase_q == ISX_PH_Q1) && i_instr_valid
                      && (dec_in.is_skip_zero || dec_in.is_skip_nonzero);
    assign phase_d     = isx_phase_t'(phase_q + 2'b01);
    assign dec_d       = accept ? dec_in : dec_q;

    // The address follows the word being taken, so it already stands when the operand is read in Q2.
    isx_addr_gen u_addr_gen
    (
        .i_file_addr            (dec_d.file_addr),
        .i_use_bank             (dec_d.use_bank),
        .i_bank_select_register (i_bank_select_register),
        .i_ext_set_en           (i_ext_set_en),
        .i_index_base           (i_index_base),
        .o_eff_addr             (eff_addr)
    );

    // Each instruction cycle spans four phases; a skip adds one or two flushed cycles.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ISX_EX_IDLE:   if (accept) state_d = ISX_EX_RUN;
            ISX_EX_RUN:    if (last_phase) state_d = skip ? ISX_EX_FLUSH : ISX_EX_IDLE;
            ISX_EX_FLUSH:  if (last_phase) state_d = two_word_q ? ISX_EX_FLUSH2 : ISX_EX_IDLE;
            ISX_EX_FLUSH2: if (last_phase) state_d = ISX_EX_IDLE;
            default:       state_d = ISX_EX_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            phase_q    <= ISX_PH_Q1;
            state_q    <= ISX_EX_IDLE;
            dec_q      <= '0;
            operand_q  <= `ISX_DATA_RESET;
            two_word_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            state_q <= state_d;
            dec_q   <= dec_d;
            if (state_q == ISX_EX_RUN && phase_q == ISX_PH_Q2)
            begin
                operand_q <= i_file_rdata;
            end
            if (state_q == ISX_EX_RUN && last_phase)
            begin
                two_word_q <= i_next_two_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Writeback is decided in Q3 of the execute cycle; outputs are registered so they show one edge later, in Q4.
    wire logic wb_now;
    assign wb_now = (state_q == ISX_EX_RUN) && (phase_q == ISX_PH_Q3);

    always_ff @(posedge i_core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            o_file_addr  <= 12'h000;
            o_file_wr    <= 1'b0;
            o_file_wdata <= `ISX_DATA_RESET;
            o_acc_wr     <= 1'b0;
            o_acc_wdata  <= `ISX_DATA_RESET;
            o_flush      <= 1'b0;
            o_busy       <= 1'b0;
            o_phase      <= 2'b00;
        end
        else
        begin
            o_file_addr  <= eff_addr;
            o_file_wr    <= wb_now && dec_q.dest_file;
            o_file_wdata <= sum;
            o_acc_wr     <= wb_now && !dec_q.dest_file;
            o_acc_wdata  <= sum;
            o_flush      <= (state_d == ISX_EX_FLUSH) || (state_d == ISX_EX_FLUSH2);
            o_busy       <= (state_d != ISX_EX_IDLE);
            o_phase      <= phase_d;
        end
    end
endmodule : isx_exec

// ===== verif/isx_exec_checker.sv
// Concurrent checks on the ports of the increment-and-skip execution unit.
`timescale 1ns/1ns
`include "isx_defs.svh"
module isx_exec_checker
    import isx_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_arst_n,
    input  wire logic [15:0] i_instr,
    input  wire logic [7:0]  i_file_rdata,
    input  wire logic        o_file_wr,
    input  wire logic [7:0]  o_file_wdata,
    input  wire logic        o_acc_wr,
    input  wire logic [7:0]  o_acc_wdata,
    input  wire logic        o_flush,
    input  wire logic        o_busy,
    input  wire logic [1:0]  o_phase
);
    logic [6:0] op_q;
    logic [3:0] busy_n_q;
    logic [3:0] flush_n_q;
    wire        wr_any = o_file_wr | o_acc_wr;
    wire  [7:0] wd     = o_file_wr ? o_file_wdata : o_acc_wdata;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // The word is copied only while idle, so it freezes on the one that was taken.
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            op_q      <= 7'h00;
            busy_n_q  <= 4'h0;
            flush_n_q <= 4'h0;
        end
        else
        begin
            op_q      <= o_busy ? op_q : i_instr[15:9];
            busy_n_q  <= o_busy ? busy_n_q + 4'h1 : 4'h0;
            flush_n_q <= o_flush ? flush_n_q + 4'h1 : 4'h0;
        end
    end
    chk_phase_step: assert property (o_phase != 2'h0 |=> o_phase == 2'($past(o_phase) + 2'h1)) else $error("phase step");
    chk_wr_one_hot: assert property (!(o_file_wr && o_acc_wr)) else $error("both writes");
    chk_wr_pulse: assert property (wr_any |=> !wr_any) else $error("write pulse too long");
    chk_dest_select: assert property (wr_any |-> o_file_wr == op_q[0]) else $error("wrong target");
    chk_sum_value: assert property (wr_any |-> wd == 8'($past(i_file_rdata, 2) + 8'h01)) else $error("bad sum");
    // The flush level rises one edge after the write, when the execute cycle ends.
    chk_skip_cond: assert property (wr_any |=> o_flush == (($past(wd) == 8'h00) ==
        ($past(op_q[6:1]) == `ISX_OPC_SKIP_ZERO))) else $error("skip decision");
    chk_flush_busy: assert property (o_flush |-> o_busy) else $error("flush while idle");
    // Busy covers Q2 to Q4 of the execute cycle, since the word is taken in Q1, plus the flushed cycles.
    chk_busy_len: assert property ($fell(o_busy) |->
        busy_n_q == 4'h3 || busy_n_q == 4'h7 || busy_n_q == 4'hb) else $error("busy length");
    chk_flush_len: assert property ($fell(o_flush) |-> flush_n_q == 4'h4 || flush_n_q == 4'h8)
        else $error("flush length");
endmodule : isx_exec_checker
bind isx_exec isx_exec_checker u_chk
(
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_instr(i_instr), .i_file_rdata(i_file_rdata),
    .o_file_wr(o_file_wr), .o_file_wdata(o_file_wdata), .o_acc_wr(o_acc_wr), .o_acc_wdata(o_acc_wdata),
    .o_flush(o_flush), .o_busy(o_busy), .o_phase(o_phase)
);

// ===== verif/isx_exec_tb.sv
// Self-checking bench for the increment-and-skip execution unit.
`timescale 1ns/1ns
`include "isx_defs.svh"
module isx_exec_tb
    import isx_pkg::*;
;
    typedef struct packed
    {
        logic [11:0] addr;
        logic [41:0] drive;
    } isx_row_t;
    logic i_core_clk = 1'b0, i_arst_n = 1'b0, i_instr_valid = 1'b0, i_next_two_word = 1'b0, i_ext_set_en = 1'b0;
    logic [15:0] i_instr = 16'h0000;
    logic [3:0]  i_bank_select_register = 4'h0;
    logic [11:0] i_index_base = 12'h000, o_file_addr;
    logic [7:0]  i_file_rdata = 8'h00, o_file_wdata, o_acc_wdata;
    logic        o_file_wr, o_acc_wr, o_flush, o_busy;
    logic [1:0]  o_phase;
    int          err_total = 0, total_checks = 0, cyc = 0;
    // Row: address expected, then word, read data, bank, extended enable, index base, two-word flag.
    isx_row_t    rows [6] = '{{12'h010, 16'h3e10, 8'hff, 4'h0, 1'b0, 12'h000, 1'b0},
        {12'h580, 16'h3d80, 8'h41, 4'h5, 1'b0, 12'h000, 1'b0}, {12'hf70, 16'h4a70, 8'h00, 4'h0, 1'b0, 12'h000, 1'b1},
        {12'h25f, 16'h485f, 8'hff, 4'h0, 1'b1, 12'h200, 1'b0}, {12'hf60, 16'h3e60, 8'hff, 4'h0, 1'b1, 12'h200, 1'b1},
        {12'h305, 16'h4b05, 8'h7f, 4'h3, 1'b1, 12'h200, 1'b0}};
    always #25 i_core_clk = ~i_core_clk;
    isx_exec uut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
        .i_next_two_word(i_next_two_word), .i_bank_select_register(i_bank_select_register),
        .i_ext_set_en(i_ext_set_en), .i_index_base(i_index_base), .i_file_rdata(i_file_rdata),
        .o_file_addr(o_file_addr), .o_file_wr(o_file_wr), .o_file_wdata(o_file_wdata), .o_acc_wr(o_acc_wr),
        .o_acc_wdata(o_acc_wdata), .o_flush(o_flush), .o_busy(o_busy), .o_phase(o_phase));
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // Waits for Q1, offers the word, holds it until busy answers, then watches the whole run.
    // Busy covers Q2 to Q4 of the execute cycle, since the word is taken in Q1, plus the flushed cycles.
    task automatic run(input isx_row_t r);
        logic [7:0] sum;
        int         nb, nf, nw, ef;
        {i_instr, i_file_rdata, i_bank_select_register, i_ext_set_en, i_index_base, i_next_two_word} = r.drive;
        sum = i_file_rdata + 8'h01;
        nb = 0;
        nf = 0;
        nw = 0;
        ef = ((i_instr[15:10] == `ISX_OPC_SKIP_ZERO) == (sum == 8'h00)) ? (i_next_two_word ? 8 : 4) : 0;
        while (o_phase !== 2'h0) @(negedge i_core_clk);
        i_instr_valid = 1'b1;
        while (o_busy !== 1'b1) @(negedge i_core_clk);
        i_instr_valid = 1'b0;
        chk("file_addr", 24'(r.addr), 24'(o_file_addr));
        while (o_busy === 1'b1)
        begin
            nb++;
            nf += (o_flush === 1'b1);
            if (o_file_wr === 1'b1 || o_acc_wr === 1'b1)
            begin
                nw++;
                chk("wr_kind", 24'(i_instr[9] ? 2'b10 : 2'b01), 24'({o_file_wr, o_acc_wr}));
                chk("wdata", 24'(sum), 24'(i_instr[9] ? o_file_wdata : o_acc_wdata));
            end
            @(negedge i_core_clk);
        end
        chk("flush_cycles", 24'(ef), 24'(nf));
        chk("busy_cycles", 24'(3 + ef), 24'(nb));
        chk("writes", 24'h1, 24'(nw));
    endtask : run
    always @(posedge i_core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            results();
        end
    end
    initial
    begin
        repeat (10) @(negedge i_core_clk);
        chk("reset_outputs", 24'h0, 24'({o_file_addr, o_file_wr, o_acc_wr, o_flush, o_busy, o_phase}));
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_core_clk);
        foreach (rows[k]) run(rows[k]);
        i_instr = 16'h2a10;
        i_instr_valid = 1'b1;
        // Busy is watched on every cycle, so a take at either Q1 of the window would show.
        repeat (8)
        begin
            @(negedge i_core_clk);
            chk("foreign_opcode_busy", 24'h0, 24'(o_busy));
        end
        i_instr = 16'h3e10;
        repeat (6) @(negedge i_core_clk);
        chk("midrun_busy", 24'h1, 24'(o_busy));
        i_arst_n = 1'b0;
        i_instr_valid = 1'b0;
        @(negedge i_core_clk);
        chk("midrun_reset", 24'h0, 24'({o_file_addr, o_file_wr, o_acc_wr, o_flush, o_busy, o_phase}));
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_core_clk);
        run(rows[2]);
        results();
    end
endmodule : isx_exec_tb
